/* File: hw/spi_chain_slave.sv */
// Purpose: serial slave port with single and daisy-chain frames
// Assumes: serial pins sampled by ref_clk at well over four times sclk
// Notes: frame mode is picked from the first byte of each frame
//
// Notes on behaviour
// - inbound word: bit15 zero, bit14 read, bits13-9 address, bits7-0 data
// - outbound word: status byte 11 plus six fault flags, then report byte
// - on write the report byte returns the old register value
// - on read the report byte returns the current register value
// - while deselected, sclk and sdi are ignored and sdo floats
// - a frame of wrong bit count is flagged and discarded
// - sample input on falling sclk, launch output on rising sclk
// - most significant bit first in both directions
// - chain returns N status bytes, two headers, N report bytes
// - first header carries a 6-bit device count, up to 63
// - clear bit in second header clears faults at chip select rise
// - low five bits of second header pass through untouched
// - each chained device adds its own status byte
// - position from status bytes before header, length from headers
// - each device captures only its own address and data bytes
// - chain bytes keep single-frame layout; report holds accessed register
// - status flags mirror the fault register at address zero
`timescale 1ns/1ps
module spi_chain_slave (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  input wire spi_chain_pkg::byte_t fault_status,
  input wire spi_chain_pkg::byte_t diag_status,
  output spi_chain_pkg::byte_t ctrl1,
  output spi_chain_pkg::byte_t ctrl2,
  output spi_chain_pkg::byte_t ctrl3,
  output spi_chain_pkg::byte_t ctrl4,
  output logic reg_write,
  output logic clear_faults,
  output logic frame_error,
  output logic chain_mode,
  output logic [spi_chain_pkg::POS_W-1:0] chain_position,
  output logic [spi_chain_pkg::POS_W-1:0] chain_device_count
);
  import spi_chain_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  logic cs_act_s;
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic cs_n_d_q;
  logic sclk_d_q;

  sync_two_flop #(
    .WIDTH(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .d({~chip_select_n, sclk, sdi}),
    .q({cs_act_s, sclk_s, sdi_s})
  );

  // select enters inverted so the cleared synchroniser reads as idle
  assign cs_n_s = ~cs_act_s;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cs_n_d_q <= 1'b1;
      sclk_d_q <= 1'b0;
    end else if (ce) begin
      cs_n_d_q <= cs_n_s;
      sclk_d_q <= sclk_s;
    end
  end

  logic frame_start;
  logic frame_end;
  logic selected;
  logic sclk_fall;
  logic sclk_rise;

  assign frame_start = cs_n_d_q & ~cs_n_s;
  assign frame_end = ~cs_n_d_q & cs_n_s;
  // clock edges count only while selected and not at a select edge
  assign selected = ~cs_n_s & ~cs_n_d_q;
  assign sclk_fall = selected & sclk_d_q & ~sclk_s;
  assign sclk_rise = selected & ~sclk_d_q & sclk_s;

  //////////////////////////////////////////////////////////////////////////
  // input shifting and bit counting

  logic [CNT_W-1:0] cnt_q;
  logic [6:0] in_sh_q;
  byte_t in_byte;
  byte_t last_byte_q;
  logic byte_done;
  logic [SLOT_W-1:0] byte_idx;

  assign in_byte = {in_sh_q, sdi_s};
  assign byte_done = sclk_fall & (cnt_q[2:0] == 3'h7);
  assign byte_idx = cnt_q[CNT_W-1:3];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (frame_start) begin
        cnt_q <= '0;
      end else if (sclk_fall && (cnt_q != '1)) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      in_sh_q <= '0;
      last_byte_q <= '0;
    end else if (ce) begin
      if (sclk_fall) begin
        in_sh_q <= in_byte[6:0];
      end
      if (byte_done) begin
        last_byte_q <= in_byte;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // byte decoder: single frame or chain position and length

  fsm_e state_q;
  logic [POS_W-1:0] pos_q;
  logic [POS_W-1:0] count_q;
  logic clr_req_q;
  logic [SLOT_W-1:0] addr_slot_q;
  logic [SLOT_W-1:0] data_slot_q;
  logic [SLOT_W-1:0] rep_slot_q;
  logic [SLOT_W-1:0] expect_q;
  logic [SLOT_W-1:0] pos_w;

  assign pos_w = {2'h0, pos_q};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_FIRST;
      pos_q <= '0;
      count_q <= '0;
      clr_req_q <= 1'b0;
      addr_slot_q <= '0;
      data_slot_q <= '0;
      rep_slot_q <= '0;
      expect_q <= '0;
    end else if (ce) begin
      if (frame_start) begin
        state_q <= ST_FIRST;
        pos_q <= '0;
        clr_req_q <= 1'b0;
        rep_slot_q <= '0;
      end else if (byte_done) begin
        case (state_q)
          ST_FIRST: begin
            if (!in_byte[7]) begin
              state_q <= ST_SINGLE;
              addr_slot_q <= 8'h00;
              data_slot_q <= 8'h01;
              rep_slot_q <= 8'h01;
              expect_q <= 8'h02;
            end else if (in_byte[7:6] == STATUS_TAG) begin
              state_q <= ST_COUNT;
              pos_q <= 6'h01;
            end else begin
              state_q <= ST_CHAIN_HEADER_SECOND;
              count_q <= in_byte[COUNT_MSB:0];
            end
          end
          ST_COUNT: begin
            if (in_byte[7:6] == STATUS_TAG && pos_q != POS_MAX) begin
              pos_q <= pos_q + 1'b1;
            end else if (in_byte[7:6] == HDR_TAG) begin
              state_q <= ST_CHAIN_HEADER_SECOND;
              count_q <= in_byte[COUNT_MSB:0];
            end else begin
              state_q <= ST_BAD;
            end
          end
          ST_CHAIN_HEADER_SECOND: begin
            if (in_byte[7:6] != HDR_TAG || count_q <= pos_q) begin
              state_q <= ST_BAD;
            end else begin
              state_q <= ST_BODY;
              clr_req_q <= in_byte[CLR_BIT];
              // own address follows own slot among the address bytes
              addr_slot_q <= SLOT_W'(2 * pos_w + 8'h02);
              rep_slot_q <= SLOT_W'(2 * pos_w + 8'h03);
              data_slot_q <= SLOT_W'(2 * pos_w + 8'h02 + {2'h0, count_q});
              expect_q <= SLOT_W'(pos_w + 8'h02 + 2 * {2'h0, count_q});
            end
          end
          ST_SINGLE, ST_BODY, ST_BAD: begin
            state_q <= state_q;
          end
          default: begin
            state_q <= ST_BAD;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register file and captured command

  byte_t ctrl_q [4];
  logic [4:0] addr_q;
  logic rw_q;
  byte_t data_q;
  byte_t rep_q;
  logic addr_hit;
  logic data_hit;

  function automatic byte_t read_reg(input logic [4:0] a);
    byte_t v;
    v = 8'h00;
    if (a == ADDR_FAULT) begin
      v = fault_status;
    end else if (a == ADDR_DIAG) begin
      v = diag_status;
    end else if (a >= ADDR_CTRL1 && a <= ADDR_CTRL4) begin
      v = ctrl_q[2'(a - ADDR_CTRL1)];
    end
    return v;
  endfunction

  assign addr_hit = byte_done & (
    (state_q == ST_FIRST & ~in_byte[7]) |
    (state_q == ST_BODY & byte_idx == addr_slot_q));
  assign data_hit = byte_done &
    (state_q == ST_SINGLE | state_q == ST_BODY) &
    (byte_idx == data_slot_q);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addr_q <= '0;
      rw_q <= 1'b1;
      data_q <= '0;
      rep_q <= '0;
    end else if (ce) begin
      if (addr_hit) begin
        addr_q <= in_byte[ADDR_MSB:ADDR_LSB];
        rw_q <= in_byte[RW_BIT];
        // value before any write of this frame, for reads and writes
        rep_q <= read_reg(in_byte[ADDR_MSB:ADDR_LSB]);
      end
      if (data_hit) begin
        data_q <= in_byte;
      end
    end
  end

  logic frame_ok;
  logic wr_ok;

  assign frame_ok = (state_q == ST_SINGLE | state_q == ST_BODY) &
    (cnt_q == {expect_q, 3'h0});
  assign wr_ok = frame_ok & ~rw_q &
    (addr_q >= ADDR_CTRL1) & (addr_q <= ADDR_CTRL4);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q[0] <= CTRL1_RST;
      ctrl_q[1] <= CTRL2_RST;
      ctrl_q[2] <= CTRL3_RST;
      ctrl_q[3] <= CTRL4_RST;
    end else if (ce && frame_end && wr_ok) begin
      ctrl_q[2'(addr_q - ADDR_CTRL1)] <= data_q;
    end
  end

  assign ctrl1 = ctrl_q[0];
  assign ctrl2 = ctrl_q[1];
  assign ctrl3 = ctrl_q[2];
  assign ctrl4 = ctrl_q[3];

  //////////////////////////////////////////////////////////////////////////
  // frame outcome pulses and chain information

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_write <= 1'b0;
      clear_faults <= 1'b0;
      frame_error <= 1'b0;
    end else if (ce) begin
      reg_write <= frame_end & wr_ok;
      frame_error <= frame_end & ~frame_ok;
      clear_faults <= frame_end & (
        (frame_ok & state_q == ST_BODY & clr_req_q) |
        (wr_ok & addr_q == ADDR_CTRL3 & data_q[CLR_FLT_BIT]));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chain_mode <= 1'b0;
      chain_position <= '0;
      chain_device_count <= '0;
    end else if (ce && frame_end && frame_ok) begin
      chain_mode <= (state_q == ST_BODY);
      chain_position <= (state_q == ST_BODY) ? pos_q : '0;
      chain_device_count <= (state_q == ST_BODY) ? count_q : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output path: own status byte, then delayed stream or own report

  byte_t status_byte;
  byte_t next_byte;

  assign status_byte = {STATUS_TAG, fault_status[FLAGS_MSB:0]};
  // later slots repeat the byte received one slot earlier
  assign next_byte = (byte_idx == rep_slot_q) ? rep_q : last_byte_q;

  byte_t out_byte_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_byte_q <= '0;
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else if (ce) begin
      if (frame_start) begin
        out_byte_q <= status_byte;
        sdo <= status_byte[7];
        sdo_oe_n <= 1'b0;
      end else if (frame_end) begin
        sdo <= 1'b0;
        sdo_oe_n <= 1'b1;
      end else if (sclk_rise) begin
        if (cnt_q[2:0] == 3'h0 && cnt_q != '0) begin
          out_byte_q <= next_byte;
          sdo <= next_byte[7];
        end else begin
          sdo <= out_byte_q[~cnt_q[2:0]];
        end
      end
    end
  end

endmodule // spi_chain_slave

/* File: inc/spi_chain_pkg.sv */
// Purpose: shared constants and types of the chained serial slave port
// Assumes: 8-bit register words, 5-bit register addresses
// Notes: all bit positions are indices inside one byte of the frame
package spi_chain_pkg;

  typedef logic [7:0] byte_t;

  // frame geometry
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 11;
  localparam int SLOT_W = 8;
  localparam int POS_W = 6;

  // command byte layout
  localparam int RW_BIT = 6;
  localparam int ADDR_MSB = 5;
  localparam int ADDR_LSB = 1;

  // header and status byte layout
  localparam logic [1:0] HDR_TAG = 2'h2;
  localparam logic [1:0] STATUS_TAG = 2'h3;
  localparam int COUNT_MSB = 5;
  localparam int CLR_BIT = 5;
  localparam int FLAGS_MSB = 5;
  localparam logic [POS_W-1:0] POS_MAX = 6'h3F;

  // register addresses
  localparam logic [4:0] ADDR_FAULT = 5'h00;
  localparam logic [4:0] ADDR_DIAG = 5'h01;
  localparam logic [4:0] ADDR_CTRL1 = 5'h02;
  localparam logic [4:0] ADDR_CTRL4 = 5'h05;
  localparam logic [4:0] ADDR_CTRL3 = 5'h04;
  localparam int CLR_FLT_BIT = 7;

  // values after reset of the four control registers
  localparam byte_t CTRL1_RST = 8'h51;
  localparam byte_t CTRL2_RST = 8'h0C;
  localparam byte_t CTRL3_RST = 8'h00;
  localparam byte_t CTRL4_RST = 8'h00;

  // byte-level decoder states
  typedef enum logic [5:0] {
    ST_FIRST  = 6'h01,
    ST_SINGLE = 6'h02,
    ST_COUNT  = 6'h04,
    ST_CHAIN_HEADER_SECOND   = 6'h08,
    ST_BODY   = 6'h10,
    ST_BAD    = 6'h20
  } fsm_e;

endpackage

/* File: hw/sync_two_flop.sv */
// Purpose: two-flop synchroniser for a group of single-bit levels
// Assumes: each bit is an independent level from another clock domain
// Notes: the first stage is read only by the second stage
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 3
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        meta_q[i] <= 1'b0;
        q[i] <= 1'b0;
      end else if (ce) begin
        meta_q[i] <= d[i];
        q[i] <= meta_q[i];
      end
    end
  end

endmodule // sync_two_flop

/* File: testbench/spi_chain_slave_assertions.sv */
// Purpose: port checks of the chained serial slave
// Assumes: sclk half period of eight or more ref_clk cycles
// Notes: bound to every spi_chain_slave instance
`timescale 1ns/1ps
module spi_chain_slave_assertions (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire spi_chain_pkg::byte_t ctrl1,
  input wire spi_chain_pkg::byte_t ctrl2,
  input wire spi_chain_pkg::byte_t ctrl3,
  input wire spi_chain_pkg::byte_t ctrl4,
  input wire logic reg_write,
  input wire logic clear_faults,
  input wire logic frame_error,
  input wire logic [spi_chain_pkg::POS_W-1:0] chain_position
);
  import spi_chain_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_idle_float: assert property (chip_select_n [*6] |-> sdo_oe_n)
    else $error("sdo driven while deselected");
  a_drive_sel: assert property (!chip_select_n [*6] |-> !sdo_oe_n)
    else $error("sdo not driven while selected");
  a_release_time: assert property ($rose(chip_select_n) |-> ##[2:6] sdo_oe_n)
    else $error("sdo not released after deselect");
  a_status_msb: assert property ($fell(sdo_oe_n) |-> sdo)
    else $error("first status bit not one");
  a_sdo_launch: assert property ((!sclk && !chip_select_n) [*8] |-> $stable(sdo))
    else $error("sdo moved while sclk low");
  a_write_at_end: assert property (reg_write |-> $past(chip_select_n, 2))
    else $error("write committed inside a frame");
  a_ctrl_on_write: assert property ($changed({ctrl1, ctrl2, ctrl3, ctrl4}) |-> reg_write)
    else $error("control changed without write");
  a_error_clean: assert property (frame_error |-> !reg_write && !clear_faults)
    else $error("bad frame had side effects");
  a_clear_at_end: assert property (clear_faults |-> $past(chip_select_n, 2) ##1 !clear_faults)
    else $error("clear pulse misplaced");
  a_pos_hold: assert property ($changed(chain_position) |-> $past(chip_select_n, 2))
    else $error("chain position moved mid frame");
endmodule // spi_chain_slave_assertions
bind spi_chain_slave spi_chain_slave_assertions spi_chain_slave_assertions_i (
  .ref_clk(ref_clk), .srst(srst), .sclk(sclk),
  .chip_select_n(chip_select_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
  .ctrl1(ctrl1), .ctrl2(ctrl2), .ctrl3(ctrl3), .ctrl4(ctrl4),
  .reg_write(reg_write), .clear_faults(clear_faults),
  .frame_error(frame_error), .chain_position(chain_position));

/* File: testbench/spi_host_model.sv */
// Purpose: behavioural serial master that sends one frame per go pulse
// Assumes: sclk half period 80 ns
// Notes: sdi shows the inverse of its last bit while deselected
`timescale 1ns/1ps
module spi_host_model (
  input wire logic go,
  input wire logic [6:0] nbits,
  input wire logic [63:0] tx,
  input wire logic sdo,
  output logic sclk,
  output logic chip_select_n,
  output logic sdi,
  output logic [63:0] rx,
  output logic busy
);
  initial begin
    sclk = 1'h0;
    chip_select_n = 1'h1;
    sdi = 1'h0;
    rx = '0;
    busy = 1'h0;
  end
  ////////////////////////////////////////
  always @(posedge go) begin
    busy = 1'h1;
    rx = '0;
    #3 chip_select_n = 1'h0;
    for (int i = 0; i < nbits; i++) begin
      #80 sclk = 1'h1;
      sdi = tx[nbits-1-i];
      #80 sclk = 1'h0;
      rx = {rx[62:0], sdo};
    end
    #80 chip_select_n = 1'h1;
    sdi = ~sdi;
    #520 busy = 1'h0;
  end
endmodule // spi_host_model

/* File: testbench/spi_chain_slave_tb.sv */
// Purpose: self-checking bench of the chained serial slave
// Assumes: fault register 0x55, diag register 0x96 held steady
// Notes: single frames come from a table, odd frames are hand-written
`timescale 1ns/1ps
module spi_chain_slave_tb;
  import spi_chain_pkg::*;
  typedef struct packed {
    logic [15:0] tx;
    logic [15:0] rx;
    logic wr;
    logic clr;
  } row_s;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic ce = 1'h1;
  byte_t fault_status = 8'h55;
  byte_t diag_status = 8'h96;
  logic go = 1'h0;
  logic [6:0] nbits = 7'h10;
  logic [63:0] tx = '0;
  logic [63:0] rx;
  logic sclk, chip_select_n, sdi, sdo, sdo_oe_n, busy;
  byte_t ctrl1, ctrl2, ctrl3, ctrl4;
  logic reg_write, clear_faults, frame_error, chain_mode;
  logic [POS_W-1:0] chain_position, chain_device_count;
  logic wr_seen, clr_seen, err_seen;
  int num_errors = 0;
  int compares = 0;
  row_s rows [14] = '{
    '{16'h4500, 16'hD551, 1'h0, 1'h0}, '{16'h04A5, 16'hD551, 1'h1, 1'h0},
    '{16'h4400, 16'hD5A5, 1'h0, 1'h0}, '{16'h063C, 16'hD50C, 1'h1, 1'h0},
    '{16'h087E, 16'hD500, 1'h1, 1'h0}, '{16'h0A3F, 16'hD500, 1'h1, 1'h0},
    '{16'h4600, 16'hD53C, 1'h0, 1'h0}, '{16'h4800, 16'hD57E, 1'h0, 1'h0},
    '{16'h4A00, 16'hD53F, 1'h0, 1'h0}, '{16'h00FF, 16'hD555, 1'h0, 1'h0},
    '{16'h4000, 16'hD555, 1'h0, 1'h0}, '{16'h4200, 16'hD596, 1'h0, 1'h0},
    '{16'h4C00, 16'hD500, 1'h0, 1'h0}, '{16'h0880, 16'hD57E, 1'h1, 1'h1}};
  always #5 ref_clk = ~ref_clk;
  spi_chain_slave spi_chain_slave_i (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .sclk(sclk),
    .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .fault_status(fault_status),
    .diag_status(diag_status), .ctrl1(ctrl1), .ctrl2(ctrl2),
    .ctrl3(ctrl3), .ctrl4(ctrl4), .reg_write(reg_write),
    .clear_faults(clear_faults), .frame_error(frame_error),
    .chain_mode(chain_mode), .chain_position(chain_position),
    .chain_device_count(chain_device_count));
  spi_host_model spi_host_model_i (
    .go(go), .nbits(nbits), .tx(tx), .sdo(sdo), .sclk(sclk),
    .chip_select_n(chip_select_n), .sdi(sdi), .rx(rx), .busy(busy));
  always @(posedge ref_clk) begin
    if (reg_write) wr_seen <= 1'h1;
    if (clear_faults) clr_seen <= 1'h1;
    if (frame_error) err_seen <= 1'h1;
  end
  ////////////////////////////////////////
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // f holds the expected pulses {write, clear, error}; d trailing bits unchecked
  task frame(input int n, input logic [63:0] t, input logic [63:0] r,
             input logic [2:0] f, input int d);
    @(posedge ref_clk);
    #1;
    nbits = n[6:0];
    tx = t;
    {wr_seen, clr_seen, err_seen} = 3'h0;
    go = 1'h1;
    @(posedge ref_clk);
    #1 go = 1'h0;
    for (int k = 0; k < 3000 && busy; k++) @(posedge ref_clk);
    chk(busy, 1'h0);
    chk(rx >> d, r);
    chk({wr_seen, clr_seen, err_seen}, f);
    $display("test done frame %h", t);
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #500000;
    num_errors++;
    test_done;
  end
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 srst = 1'h0;
    repeat (6) @(posedge ref_clk);
    chk({ctrl1, ctrl2, ctrl3, ctrl4}, {CTRL1_RST, CTRL2_RST, 16'h0000});
    chk({sdo_oe_n, reg_write, clear_faults, frame_error, chain_mode,
         chain_position, chain_device_count}, {5'h10, 12'h000});
    $display("test done reset");
    foreach (rows[i]) begin
      frame(16, rows[i].tx, rows[i].rx, {rows[i].wr, rows[i].clr, 1'h0}, 0);
    end
    chk({ctrl1, ctrl2, ctrl3, ctrl4}, 32'hA53C803F);
    // short and long frames must leave ctrl1 alone
    frame(15, 64'h0209, 64'h6AD2, 3'h1, 0);
    frame(17, 64'h0822, 64'hD5A5, 3'h1, 1);
    frame(16, 64'h4400, 64'hD5A5, 3'h0, 0);
    // second of two devices: clear set, low header bits passed through
    frame(56, 64'hC382B55A447700, 64'hD5C382B55AA577, 3'h2, 0);
    chk({chain_mode, chain_position, chain_device_count}, 13'h1042);
    // only device of a chain writes ctrl4
    frame(32, 64'h81800A99, 64'hD581803F, 3'h4, 0);
    chk({ctrl4, chain_mode, chain_position, chain_device_count}, 21'h133001);
    frame(40, 64'h81800A1200, 64'hD5818099, 3'h1, 8);
    frame(16, 64'h4A00, 64'hD599, 3'h0, 0);
    chk(chain_mode, 1'h0);
    test_done;
  end
endmodule // spi_chain_slave_tb
